// ===== logic/pbc_bank.sv
// burst configuration bank with ethernet burst gating and error merge
// What this block does
// - register accesses are honoured only from supervisor masters
// - bank decodes at fixed base, three words at offsets 0, 4, 8
// - ethernet burst control register resets to all zeros
// - both gasket registers reset to 0707_0707
// - burst control bits 0 to 20 read zero, ignore writes
// - first half of write burst is acked to fifo before being written
// - with accumulate off, first half bus error is dropped
// - with accumulate on, first half error shows on second half
// - global write burst bit gates write bursts with per-port enables
// - global read burst bit gates read bursts with per-port enables
// - eight per-port enables; zero means single transfers only
// - ports: flash, ext bus, ram, reserved x3, bridge a, bridge b
// - pending read enable disables pending reads when zero
// - burst read enable zero splits reads, one optimizes
// - burst write enable zero splits, one optimizes imprecisely
// - first gasket register at offset 4, bits 0 to 4 read zero
// - first gasket register has core1 instruction group at bit 13
`timescale 1ns/1ps
module pbc_bank (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire pbc_pkg::pbc_bus_req_type bus_req,
    output pbc_pkg::pbc_bus_rsp_type     bus_rsp,
    input  wire pbc_pkg::pbc_eth_req_type eth_req,
    output logic                         eth_ready,
    output pbc_pkg::pbc_grant_type       eth_grant,
    input  wire pbc_pkg::pbc_resp_type   system_crossbar_rsp,
    output pbc_pkg::pbc_resp_type        fifo_rsp,
    output pbc_pkg::pbc_gasket_type      gasket_en [8]
);
    import pbc_pkg::*;

    typedef struct packed {
        pbc_bus_rsp_type bus_rsp;
        logic [31:0]     burst_ctrl;
        logic [31:0]     gasket1;
        logic [31:0]     gasket2;
        pbc_fsm_type     fsm;
        logic            ready;
        pbc_grant_type   grant;
        pbc_resp_type    fifo_rsp;
        logic            pend_err;
        logic            acc;
    } pbc_state_type;

    pbc_state_type state_q;
    pbc_state_type state_d;

    logic        hit;
    logic [3:0]  offset;
    logic        port_en;
    logic        take;
    logic        burst_ok;

    // address decode of the three words
    always_comb begin
        offset = bus_req.addr[3:0];
        hit = (bus_req.addr[31:4] == BASE_ADDR[31:4]) &&
              ((offset == OFF_BURST) || (offset == OFF_GASKET1) ||
               (offset == OFF_GASKET2));
    end

    // burst permission of the requested port; port n is word bit n
    always_comb begin
        port_en  = state_q.burst_ctrl[PORT_LSB + 32'(eth_req.port)];
        take     = eth_req.valid && state_q.ready;
        if (eth_req.write) begin
            burst_ok = eth_req.burst && port_en &&
                       state_q.burst_ctrl[GLOBAL_WRITE_BURST_ENABLE_BIT];
        end else begin
            burst_ok = eth_req.burst && port_en &&
                       state_q.burst_ctrl[GLOBAL_READ_BURST_ENABLE_BIT];
        end
    end

    always_comb begin
        state_d = state_q;
        state_d.bus_rsp = '0;
        state_d.grant = '0;
        state_d.fifo_rsp = '0;

        // register access, answered one cycle after the select
        if (bus_req.sel) begin
            state_d.bus_rsp.ready = 1'b1;
            if (!bus_req.supervisor || !hit) begin
                state_d.bus_rsp.err = 1'b1;
            end else if (bus_req.wr) begin
                case (offset)
                    OFF_BURST: begin
                        state_d.burst_ctrl =
                            bus_req.wdata & MASK_BURST;
                    end
                    OFF_GASKET1: begin
                        state_d.gasket1 =
                            bus_req.wdata & MASK_GASKET;
                    end
                    OFF_GASKET2: begin
                        state_d.gasket2 = bus_req.wdata & MASK_GASKET;
                    end
                    default: begin
                        state_d.bus_rsp.err = 1'b1;
                    end
                endcase
            end else begin
                case (offset)
                    OFF_BURST: begin
                        state_d.bus_rsp.rdata = state_q.burst_ctrl;
                    end
                    OFF_GASKET1: begin
                        state_d.bus_rsp.rdata = state_q.gasket1;
                    end
                    OFF_GASKET2: begin
                        state_d.bus_rsp.rdata = state_q.gasket2;
                    end
                    default: begin
                        state_d.bus_rsp.err = 1'b1;
                    end
                endcase
            end
        end

        // ethernet request gating and split write burst sequence
        case (state_q.fsm)
            PBC_IDLE: begin
                if (take) begin
                    state_d.grant.valid = 1'b1;
                    state_d.grant.burst = burst_ok;
                    if (eth_req.write && burst_ok) begin
                        // fifo sees first half done before it is written
                        state_d.fifo_rsp.valid = 1'b1;
                        state_d.fifo_rsp.err = 1'b0;
                        state_d.acc = state_q.burst_ctrl[ACC_BIT];
                        state_d.pend_err = 1'b0;
                        state_d.fsm = PBC_FIRST;
                        state_d.ready = 1'b0;
                    end
                end
            end
            PBC_FIRST: begin
                if (system_crossbar_rsp.valid) begin
                    // keep or drop the first half error
                    state_d.pend_err = system_crossbar_rsp.err && state_q.acc;
                    state_d.fsm = PBC_SECOND;
                end
            end
            PBC_SECOND: begin
                if (system_crossbar_rsp.valid) begin
                    state_d.fifo_rsp.valid = 1'b1;
                    state_d.fifo_rsp.err = system_crossbar_rsp.err ||
                                           state_q.pend_err;
                    state_d.pend_err = 1'b0;
                    state_d.fsm = PBC_IDLE;
                    state_d.ready = 1'b1;
                end
            end
            default: begin
                state_d.fsm = PBC_IDLE;
                state_d.ready = 1'b1;
                state_d.pend_err = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q.bus_rsp    <= '0;
            state_q.burst_ctrl <= RST_BURST;
            state_q.gasket1    <= RST_GASKET;
            state_q.gasket2    <= RST_GASKET;
            state_q.fsm        <= PBC_IDLE;
            state_q.ready      <= 1'b1;
            state_q.grant      <= '0;
            state_q.fifo_rsp   <= '0;
            state_q.pend_err   <= 1'b0;
            state_q.acc        <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    assign bus_rsp   = state_q.bus_rsp;
    assign eth_ready = state_q.ready;
    assign eth_grant = state_q.grant;
    assign fifo_rsp  = state_q.fifo_rsp;

    // gasket masters: core1 data, core1 instr, core0 data, core0 instr,
    // ethernet, concentrator, dma b, dma a; each byte's low three bits
    for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_gasket
        localparam int LSB = 8 * (3 - (m % 4));
        pbc_gasket_stage u_stage (
            .clock   (clock),
            .rst_n   (rst_n),
            .field   (m < 4 ? state_q.gasket1[LSB +: 3]
                            : state_q.gasket2[LSB +: 3]),
            .enables (gasket_en[m])
        );
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_first_err;
        state_q.fsm == PBC_FIRST && system_crossbar_rsp.valid && system_crossbar_rsp.err;
    endsequence

    sequence s_second_clean;
        state_q.fsm == PBC_SECOND && system_crossbar_rsp.valid && !system_crossbar_rsp.err;
    endsequence

    sequence s_second_err;
        state_q.fsm == PBC_SECOND && system_crossbar_rsp.valid && system_crossbar_rsp.err;
    endsequence

    sequence s_write_burst_taken;
        take && eth_req.write && burst_ok;
    endsequence

    a_user_refused: assert property (
        bus_req.sel && !bus_req.supervisor
        |=> bus_rsp.ready && bus_rsp.err && bus_rsp.rdata == '0
            && $stable(state_q.burst_ctrl) && $stable(state_q.gasket1))
        else $error("user mode access not refused");

    a_word_map: assert property (
        bus_req.sel && bus_req.supervisor && !bus_req.wr
        && bus_req.addr == (BASE_ADDR | 32'h4)
        |=> bus_rsp.rdata == $past(state_q.gasket1) && !bus_rsp.err)
        else $error("offset 4 does not read first gasket word");

    a_reset_values: assert property (
        $rose(rst_n) |-> state_q.burst_ctrl == RST_BURST
            && state_q.gasket1 == RST_GASKET
            && state_q.gasket2 == RST_GASKET)
        else $error("reset values wrong");

    a_reserved_zero: assert property (
        state_q.burst_ctrl[31:11] == '0 && state_q.gasket1[31:27] == '0)
        else $error("reserved bits not zero");

    a_early_ack: assert property (
        take && eth_req.write && burst_ok
        |=> fifo_rsp.valid && !fifo_rsp.err && eth_grant.burst
            && state_q.fsm == PBC_FIRST)
        else $error("first half not acked early");

    a_drop_error: assert property (
        (s_first_err ##0 !state_q.acc) ##1 s_second_clean
        |=> fifo_rsp.valid && !fifo_rsp.err)
        else $error("first half error not dropped");

    a_keep_error: assert property (
        (s_first_err ##0 state_q.acc) ##1 s_second_clean
        |=> fifo_rsp.valid && fifo_rsp.err)
        else $error("first half error not merged");

    a_write_gate: assert property (
        take && eth_req.write && eth_req.burst
        |=> eth_grant.valid && eth_grant.burst ==
            ($past(state_q.burst_ctrl[GLOBAL_WRITE_BURST_ENABLE_BIT]) &&
             $past(port_en)))
        else $error("write burst gating wrong");

    a_read_gate: assert property (
        take && !eth_req.write && eth_req.burst
        && !state_q.burst_ctrl[PORT_LSB + 32'(eth_req.port)]
        |=> eth_grant.valid && !eth_grant.burst)
        else $error("read burst to disabled port");

    a_gasket_core1: assert property (
        ##1 gasket_en[0] == $past(state_q.gasket1[26:24])
            && gasket_en[1] == $past(state_q.gasket1[18:16]))
        else $error("core1 gasket groups wrong");

    a_super_write: assert property (
        bus_req.sel && bus_req.supervisor && bus_req.wr
        && bus_req.addr == BASE_ADDR
        |=> bus_rsp.ready && !bus_rsp.err
            && state_q.burst_ctrl == ($past(bus_req.wdata) & MASK_BURST))
        else $error("supervisor write to burst word lost");

    a_unmapped_err: assert property (
        bus_req.sel && !hit
        |=> bus_rsp.ready && bus_rsp.err && bus_rsp.rdata == '0)
        else $error("unmapped access not refused");

    a_ready_pulse: assert property (
        !bus_req.sel |=> !bus_rsp.ready)
        else $error("bus answer without request");

    a_gasket_mask: assert property (
        (state_q.gasket1 & ~MASK_GASKET) == '0
        && (state_q.gasket2 & ~MASK_GASKET) == '0)
        else $error("gasket reserved bits not zero");

    a_gasket_core0: assert property (
        ##1 gasket_en[2] == $past(state_q.gasket1[10:8])
            && gasket_en[3] == $past(state_q.gasket1[2:0]))
        else $error("core0 gasket groups wrong");

    a_gasket_second: assert property (
        ##1 gasket_en[4] == $past(state_q.gasket2[26:24])
            && gasket_en[5] == $past(state_q.gasket2[18:16]))
        else $error("second word gasket groups wrong");

    a_gasket_dma: assert property (
        ##1 gasket_en[6] == $past(state_q.gasket2[10:8])
            && gasket_en[7] == $past(state_q.gasket2[2:0]))
        else $error("dma gasket groups wrong");

    a_write_off: assert property (
        take && eth_req.write && !state_q.burst_ctrl[GLOBAL_WRITE_BURST_ENABLE_BIT]
        |=> eth_grant.valid && !eth_grant.burst)
        else $error("write burst with global enable off");

    a_read_off: assert property (
        take && !eth_req.write && !state_q.burst_ctrl[GLOBAL_READ_BURST_ENABLE_BIT]
        |=> eth_grant.valid && !eth_grant.burst)
        else $error("read burst with global enable off");

    a_single_ask: assert property (
        take && !eth_req.burst |=> eth_grant.valid && !eth_grant.burst)
        else $error("burst granted to single request");

    a_port_ends: assert property (
        take && eth_req.burst && !eth_req.write
        && state_q.burst_ctrl[GLOBAL_READ_BURST_ENABLE_BIT]
        && (eth_req.port == PORT_FLASH || eth_req.port == PORT_BRIDGEB)
        |=> eth_grant.burst == $past(eth_req.port == PORT_FLASH
            ? state_q.burst_ctrl[PORT_FLASH]
            : state_q.burst_ctrl[PORT_BRIDGEB]))
        else $error("end port enable mapping wrong");

    a_second_err: assert property (
        s_second_err |=> fifo_rsp.valid && fifo_rsp.err)
        else $error("second half error not reported");

    a_acc_latched: assert property (
        s_write_burst_taken
        |=> state_q.acc == $past(state_q.burst_ctrl[ACC_BIT]))
        else $error("accumulate choice not latched at start");

    a_ready_back: assert property (
        state_q.fsm == PBC_SECOND && system_crossbar_rsp.valid
        |=> eth_ready && state_q.fsm == PBC_IDLE)
        else $error("ready not back after second half");

    a_no_stray_fifo: assert property (
        !(take && eth_req.write && burst_ok)
        && !(state_q.fsm == PBC_SECOND && system_crossbar_rsp.valid)
        |=> !fifo_rsp.valid)
        else $error("fifo answer without cause");
endmodule : pbc_bank

// ===== logic/pbc_pkg.sv
// shared constants and carrier types of the burst configuration bank
package pbc_pkg;
    localparam logic [31:0] BASE_ADDR    = 32'hfff6_c000;
    localparam logic [3:0]  OFF_BURST    = 4'h0;
    localparam logic [3:0]  OFF_GASKET1  = 4'h4;
    localparam logic [3:0]  OFF_GASKET2  = 4'h8;
    localparam logic [31:0] RST_BURST    = 32'h0000_0000;
    localparam logic [31:0] RST_GASKET   = 32'h0707_0707;
    localparam logic [31:0] MASK_BURST   = 32'h0000_07ff;
    localparam logic [31:0] MASK_GASKET  = 32'h0707_0707;
    // word bit = 31 - printed bit
    localparam int          ACC_BIT      = 10;
    localparam int          GLOBAL_WRITE_BURST_ENABLE_BIT     = 9;
    localparam int          GLOBAL_READ_BURST_ENABLE_BIT     = 8;
    localparam int          PORT_LSB     = 0;
    localparam int          PRE_OFS      = 2;
    localparam int          BRE_OFS      = 1;
    localparam int          BWE_OFS      = 0;
    localparam logic [2:0]  GASKET_RST   = 3'h7;
    localparam logic [2:0]  PORT_FLASH   = 3'h0;
    localparam logic [2:0]  PORT_EXTBUS  = 3'h1;
    localparam logic [2:0]  PORT_RAM     = 3'h2;
    localparam logic [2:0]  PORT_BRIDGEA = 3'h6;
    localparam logic [2:0]  PORT_BRIDGEB = 3'h7;
    localparam int          NUM_MASTERS  = 8;

    typedef enum logic [2:0] {
        PBC_IDLE   = 3'b001,
        PBC_FIRST  = 3'b010,
        PBC_SECOND = 3'b100
    } pbc_fsm_type;

    typedef struct packed {
        logic        sel;
        logic        wr;
        logic        supervisor;
        logic [31:0] addr;
        logic [31:0] wdata;
    } pbc_bus_req_type;

    typedef struct packed {
        logic        ready;
        logic        err;
        logic [31:0] rdata;
    } pbc_bus_rsp_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       burst;
        logic [2:0] port;
    } pbc_eth_req_type;

    typedef struct packed {
        logic valid;
        logic burst;
    } pbc_grant_type;

    typedef struct packed {
        logic valid;
        logic err;
    } pbc_resp_type;

    typedef struct packed {
        logic pending_read_en;
        logic burst_read_en;
        logic burst_write_en;
    } pbc_gasket_type;
endpackage : pbc_pkg

// ===== logic/pbc_gasket_stage.sv
// one master's registered gasket option outputs
`timescale 1ns/1ps
module pbc_gasket_stage (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic [2:0]              field,
    output pbc_pkg::pbc_gasket_type      enables
);
    import pbc_pkg::*;

    pbc_gasket_type state_q;
    pbc_gasket_type state_d;

    always_comb begin
        state_d.pending_read_en = field[PRE_OFS];
        state_d.burst_read_en   = field[BRE_OFS];
        state_d.burst_write_en  = field[BWE_OFS];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= GASKET_RST;
        end else begin
            state_q <= state_d;
        end
    end

    assign enables = state_q;
endmodule : pbc_gasket_stage

// ===== tb/pbc_system_crossbar_model.sv
// crossbar slave model answering the two halves of a write burst
`timescale 1ns/1ps
module pbc_system_crossbar_model (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic [1:0]       errs,
    input  wire logic [3:0]       gap,
    output pbc_pkg::pbc_resp_type rsp
);
    import pbc_pkg::*;
    int cnt;
    int half;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rsp <= '0;
            cnt <= 0;
            half <= 0;
        end else begin
            rsp.valid <= 1'b0;
            rsp.err <= ~rsp.err; // error line is junk between answers
            if (start) begin
                half <= 1;
                cnt <= gap;
            end else if (half != 0) begin
                if (cnt == 0) begin
                    rsp.valid <= 1'b1;
                    rsp.err <= errs[half-1];
                    half <= (half == 2) ? 0 : 2;
                    cnt <= gap;
                end else begin
                    cnt <= cnt - 1;
                end
            end
        end
    end
endmodule : pbc_system_crossbar_model

// ===== tb/pbc_bank_tb_top.sv
// self-checking testbench of the burst configuration bank
`timescale 1ns/1ps
module pbc_bank_tb_top;
    import pbc_pkg::*;
    logic            clock;
    logic            rst_n;
    pbc_bus_req_type bus_req;
    pbc_bus_rsp_type bus_rsp;
    pbc_eth_req_type eth_req;
    logic            eth_ready;
    pbc_grant_type   eth_grant;
    pbc_resp_type    system_crossbar_rsp;
    pbc_resp_type    fifo_rsp;
    pbc_gasket_type  gasket_en [8];
    logic            start;
    logic [1:0]      errs;
    logic [3:0]      gap;
    int              err_total;
    int              cmp_count;
    int              seed;
    logic [31:0]     rd;
    logic [31:0]     w1;
    logic [31:0]     w2;
    logic            e;

    pbc_bank pbc_bank_i (.clock(clock), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rsp(bus_rsp), .eth_req(eth_req), .eth_ready(eth_ready),
        .eth_grant(eth_grant), .system_crossbar_rsp(system_crossbar_rsp), .fifo_rsp(fifo_rsp),
        .gasket_en(gasket_en));
    pbc_system_crossbar_model pbc_system_crossbar_model_i (.clock(clock), .rst_n(rst_n),
        .start(start), .errs(errs), .gap(gap), .rsp(system_crossbar_rsp));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic give_verdict;
        $display("mismatches %0d of %0d checks", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bound(int i, int n);
        if (i >= n) begin
            err_total++;
            $display("BAD wait expected answer seen none");
            give_verdict();
        end
    endtask : bound

    task automatic bus(logic wr, logic sup, logic [31:0] a, logic [31:0] d,
                       output logic [31:0] q, output logic er);
        int i;
        bus_req = '{1'b1, wr, sup, a, d};
        @(posedge clock);
        @(negedge clock);
        bus_req.sel = 1'b0;
        for (i = 0; i < 4 && bus_rsp.ready !== 1'b1; i++) @(negedge clock);
        bound(i, 4);
        q = bus_rsp.rdata;
        er = bus_rsp.err;
        @(negedge clock);
    endtask : bus

    function automatic logic exp_burst(logic [31:0] r, logic w, logic b,
                                       logic [2:0] p);
        return b & r[PORT_LSB + p] & (w ? r[GLOBAL_WRITE_BURST_ENABLE_BIT] : r[GLOBAL_READ_BURST_ENABLE_BIT]);
    endfunction : exp_burst

    task automatic eth(logic [31:0] r, logic w, logic b, logic [2:0] p,
                       logic [1:0] ee);
        int i;
        logic x;
        bus(1'b1, 1'b1, BASE_ADDR, r, rd, e);
        eth_req = '{1'b1, w, b, p};
        @(posedge clock);
        @(negedge clock);
        eth_req.valid = 1'b0;
        for (i = 0; i < 4 && eth_grant.valid !== 1'b1; i++) @(negedge clock);
        bound(i, 4);
        check("grant burst", exp_burst(r, w, b, p), eth_grant.burst);
        if (eth_grant.burst === 1'b1 && w) begin
            check("early ack", 32'h4, {fifo_rsp, eth_ready});
            errs = ee;
            start = 1'b1;
            @(negedge clock);
            start = 1'b0;
            for (i = 0; i < 60 && fifo_rsp.valid !== 1'b1; i++)
                @(negedge clock);
            bound(i, 60);
            x = ee[1] | (ee[0] & r[ACC_BIT]);
            check("burst err", x, fifo_rsp.err);
        end
    endtask : eth

    initial begin
        seed = 32'hd92675a9;
        rst_n = 1'b0;
        bus_req = '0;
        eth_req = '0;
        start = 1'b0;
        errs = 2'h0;
        gap = 4'h0;
        repeat (8) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        for (int k = 0; k < 8; k++)
            check("gasket rst", 32'h7, gasket_en[k]);
        for (int k = 0; k < 3; k++) begin
            bus(1'b0, 1'b1, BASE_ADDR + 4 * k, 32'h0, rd, e);
            check("reset word", k ? RST_GASKET : RST_BURST, rd);
        end
        bus(1'b1, 1'b1, BASE_ADDR, 32'hffff_ffff, rd, e);
        bus(1'b0, 1'b1, BASE_ADDR, 32'h0, rd, e);
        check("burst mask", 32'h0000_07ff, rd);
        bus(1'b1, 1'b1, BASE_ADDR + 4, 32'hffff_ffff, rd, e);
        bus(1'b0, 1'b1, BASE_ADDR + 4, 32'h0, rd, e);
        check("gasket mask", 32'h0707_0707, rd);
        bus(1'b1, 1'b0, BASE_ADDR, 32'h0, rd, e);
        check("user err", 32'h1, e);
        bus(1'b0, 1'b0, BASE_ADDR, 32'h0, rd, e);
        check("user read", 32'h0, rd);
        check("user read err", 32'h1, e);
        bus(1'b0, 1'b1, BASE_ADDR, 32'h0, rd, e);
        check("user kept", 32'h0000_07ff, rd);
        bus(1'b0, 1'b1, BASE_ADDR + 32'hc, 32'h0, rd, e);
        check("unmapped", 32'h1, e);
        bus(1'b0, 1'b1, BASE_ADDR ^ 32'h0001_0000, 32'h0, rd, e);
        check("off base", 32'h1, e);
        repeat (6) begin
            w1 = $random(seed);
            w2 = $random(seed);
            bus(1'b1, 1'b1, BASE_ADDR + 4, w1, rd, e);
            bus(1'b1, 1'b1, BASE_ADDR + 8, w2, rd, e);
            @(negedge clock);
            for (int m = 0; m < 8; m++)
                check("gasket field", m < 4 ? w1[26-8*m -: 3] :
                      w2[26-8*(m-4) -: 3], gasket_en[m]);
        end
        for (int p = 0; p < 8; p++) begin
            eth(32'h0000_07ff, 1'b1, 1'b1, p[2:0], 2'b01);
            eth(32'h0000_03ff, 1'b1, 1'b1, p[2:0], 2'b01);
            w1 = 32'h0000_07ff & ~(32'h1 << p);
            eth(w1, 1'b0, 1'b1, p[2:0], 2'b00);
        end
        repeat (40) begin
            w1 = $random(seed) & MASK_BURST;
            w2 = $random(seed);
            gap = w2[11:8];
            eth(w1, w2[0], w2[1] | w2[2], w2[5:3], w2[7:6]);
        end
        give_verdict();
    end
endmodule : pbc_bank_tb_top
